// ### serial_flash_cfg.svh
/*
  Offsets, field positions, reset values and command codes of the serial flash bus interface.
  Assumes it is included by bare name wherever the numbers are needed.
*/
`ifndef SERIAL_FLASH_CFG_SVH
`define SERIAL_FLASH_CFG_SVH

// Register byte addresses on the APB side
`define OFS_CTRL        12'h000
`define OFS_REG_BYTE    12'h004
`define OFS_LAST_CMD    12'h008
`define OFS_ADDR        12'h00c
`define OFS_SECTOR      12'h010
`define OFS_RX_DATA     12'h014
`define OFS_STATE       12'h018

// Control fields
`define CTRL_QUAD_BIT   0
`define CTRL_FOUR_BIT   1
`define CTRL_RESET      2'h0
`define REG_BYTE_RESET  8'h00

// Command codes understood on the link
`define CMD_REG_READ    8'h05
`define CMD_PARAM_READ  8'h5a

// Address map
`define ADDR_MSB        22
`define SECTOR_LSB      12
`define BLK32_LSB       15
`define BLK64_LSB       16

// Parameter header, byte 0 in the top bits; table id FF00h sits at bytes 08h and 0Fh
`define PARAM_HDR       128'h53464450_060100ff_00060110_300000ff
`define PARAM_HDR_LEN   8'h10
`define PARAM_FILL      8'hff

`endif

// ### serial_flash_pkg.sv
/*
  Types of the serial flash bus interface: pin groups, APB groups, transfer states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package serial_flash_pkg;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       reset_n;
    logic [3:0] io;
  } pin_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] io_oe;
  } pin_out_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_OUT,
    ST_DATA_IN
  } xfer_state_t;

endpackage : serial_flash_pkg
`default_nettype wire

// ### serial_flash_bus_interface.sv
/*
  Slave side of the serial flash link with its APB register file.
  Assumes the link pins arrive asynchronously and are synchronised here, that the serial clock
  runs well below a quarter of clk_sys_i, and that APB shares clk_sys_i and rst_i.
*/
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "serial_flash_cfg.svh"

module serial_flash_bus_interface (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire serial_flash_pkg::apb_req_t apb_i,
  output var  serial_flash_pkg::apb_rsp_t apb_o,
  input  wire serial_flash_pkg::pin_in_t  pins_i,
  output var  serial_flash_pkg::pin_out_t pins_o
);
  import serial_flash_pkg::*;

  function automatic logic [7:0] param_byte(input logic [7:0] idx);
    logic [127:0] hdr;
    hdr = `PARAM_HDR;
    if (idx < `PARAM_HDR_LEN) begin
      param_byte = hdr[8'd127 - {idx[3:0], 3'b000} -: 8];
    end else begin
      param_byte = `PARAM_FILL;
    end
  endfunction : param_byte

  pin_in_t     pin_m_reg;
  pin_in_t     pin_s_reg;
  logic        sck_d_reg;
  xfer_state_t state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  tx_sh_reg;
  logic [1:0]  addr_cnt_reg;
  logic [23:0] addr_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  rx_data_reg;
  logic [7:0]  rx_cnt_reg;
  logic [3:0]  io_out_reg;
  logic [3:0]  io_oe_reg;
  logic [1:0]  ctrl_reg;
  logic [7:0]  reg_byte_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  // Link decoding; only the second synchroniser stage is looked at
  wire        sck_s       = pin_s_reg.sck;
  wire        cs_n_s      = pin_s_reg.cs_n;
  wire        rstn_s      = pin_s_reg.reset_n;
  wire [3:0]  io_s        = pin_s_reg.io;
  wire        quad_io_enable         = ctrl_reg[`CTRL_QUAD_BIT];
  wire        four_wire_command_mode = ctrl_reg[`CTRL_FOUR_BIT];
  // Edges are found the same way whatever level the clock idles at, so no mode setting exists
  wire        sck_rise    = sck_s & ~sck_d_reg;
  wire        sck_fall    = ~sck_s & sck_d_reg;
  // Pin 3 is the pause input only while it is not a data line
  wire        paused      = ~cs_n_s & ~io_s[3] & ~quad_io_enable & ~four_wire_command_mode;
  wire        cs_clear    = cs_n_s | ~rstn_s;
  wire [7:0]  rx_byte     = four_wire_command_mode ? {sh_reg[3:0], io_s} : {sh_reg[6:0], io_s[0]};
  wire [2:0]  bit_step    = four_wire_command_mode ? 3'h4 : 3'h1;
  wire [2:0]  bit_cnt_next = bit_cnt_reg + bit_step;
  wire        byte_done   = (bit_cnt_next == 3'h0);
  wire [10:0] sector_w    = addr_reg[`ADDR_MSB:`SECTOR_LSB];
  wire [7:0]  blk32_w     = addr_reg[`ADDR_MSB:`BLK32_LSB];
  wire [6:0]  blk64_w     = addr_reg[`ADDR_MSB:`BLK64_LSB];
  wire [7:0]  next_out    = (cmd_reg == `CMD_REG_READ) ? reg_byte_reg : param_byte(addr_reg[7:0]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_m_reg <= '1;
      pin_s_reg <= '1;
      sck_d_reg <= 1'b0;
    end else begin
      pin_m_reg <= pins_i;
      pin_s_reg <= pin_m_reg;
      sck_d_reg <= pin_s_reg.sck;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg    <= ST_CMD;
      bit_cnt_reg  <= 3'h0;
      sh_reg       <= 8'h00;
      tx_sh_reg    <= 8'h00;
      addr_cnt_reg <= 2'h0;
      addr_reg     <= 24'h000000;
      cmd_reg      <= 8'h00;
      rx_data_reg  <= 8'h00;
      rx_cnt_reg   <= 8'h00;
      io_out_reg   <= 4'h0;
      io_oe_reg    <= 4'h0;
    end else if (cs_clear) begin
      // Deselect or reset pin ends the sequence and floats every line
      state_reg   <= ST_CMD;
      bit_cnt_reg <= 3'h0;
      io_oe_reg   <= 4'h0;
    end else if (paused) begin
      // Counters are left alone so the sequence picks up where it stopped
      io_oe_reg <= 4'h0;
    end else if (sck_rise) begin
      sh_reg      <= rx_byte;
      bit_cnt_reg <= bit_cnt_next;
      if (byte_done) begin
        case (state_reg)
          ST_CMD: begin
            cmd_reg      <= rx_byte;
            addr_cnt_reg <= 2'h0;
            tx_sh_reg    <= reg_byte_reg;
            state_reg    <= (rx_byte == `CMD_REG_READ) ? ST_OUT : ST_ADDR;
          end
          ST_ADDR: begin
            addr_reg     <= {addr_reg[15:0], rx_byte};
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
            if (addr_cnt_reg == 2'h2) begin
              state_reg <= (cmd_reg == `CMD_PARAM_READ) ? ST_DUMMY : ST_DATA_IN;
            end
          end
          ST_DUMMY: begin
            tx_sh_reg <= param_byte(addr_reg[7:0]);
            addr_reg  <= addr_reg + 24'h000001;
            state_reg <= ST_OUT;
          end
          ST_OUT: begin
            // A register read reloads the same byte for as long as the master clocks
            tx_sh_reg <= next_out;
            if (cmd_reg != `CMD_REG_READ) begin
              addr_reg <= addr_reg + 24'h000001;
            end
          end
          ST_DATA_IN: begin
            rx_data_reg <= rx_byte;
            rx_cnt_reg  <= rx_cnt_reg + 8'h01;
          end
          default: begin
            state_reg <= ST_CMD;
          end
        endcase
      end
    end else if (sck_fall && state_reg == ST_OUT) begin
      if (four_wire_command_mode) begin
        io_out_reg <= tx_sh_reg[7:4];
        io_oe_reg  <= 4'hf;
        tx_sh_reg  <= {tx_sh_reg[3:0], 4'h0};
      end else begin
        io_out_reg <= {2'b00, tx_sh_reg[7], 1'b0};
        io_oe_reg  <= 4'h2;
        tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
      end
    end
  end

  // APB slave: one wait state, the access completes on the edge that sees pready high
  wire        apb_access = apb_i.psel & apb_i.penable;
  wire        apb_write  = apb_access & pready_reg & apb_i.pwrite;
  wire        hit_ctrl   = apb_i.paddr == `OFS_CTRL;
  wire        hit_byte   = apb_i.paddr == `OFS_REG_BYTE;
  wire        hit_cmd    = apb_i.paddr == `OFS_LAST_CMD;
  wire        hit_addr   = apb_i.paddr == `OFS_ADDR;
  wire        hit_sector = apb_i.paddr == `OFS_SECTOR;
  wire        hit_rx     = apb_i.paddr == `OFS_RX_DATA;
  wire        hit_state  = apb_i.paddr == `OFS_STATE;
  wire        hit_any    = hit_ctrl | hit_byte | hit_cmd | hit_addr | hit_sector | hit_rx | hit_state;
  wire [31:0] rd_word    =
    hit_ctrl   ? {30'h0, ctrl_reg} :
    hit_byte   ? {24'h0, reg_byte_reg} :
    hit_cmd    ? {24'h0, cmd_reg} :
    hit_addr   ? {9'h0, addr_reg[`ADDR_MSB:0]} :
    hit_sector ? {1'b0, blk64_w, blk32_w, 5'h0, sector_w} :
    hit_rx     ? {16'h0, rx_cnt_reg, rx_data_reg} :
    hit_state  ? {28'h0, io_oe_reg != 4'h0, ~rstn_s, paused, ~cs_n_s} :
                 32'h0;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_reg     <= `CTRL_RESET;
      reg_byte_reg <= `REG_BYTE_RESET;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= 32'h0;
    end else begin
      pready_reg  <= apb_access & ~pready_reg;
      pslverr_reg <= apb_access & ~pready_reg & ~hit_any;
      prdata_reg  <= (apb_access & ~pready_reg & ~apb_i.pwrite) ? rd_word : 32'h0;
      if (apb_write && hit_ctrl) begin
        ctrl_reg <= apb_i.pwdata[1:0];
      end
      if (apb_write && hit_byte) begin
        reg_byte_reg <= apb_i.pwdata[7:0];
      end
    end
  end

  assign apb_o.pready  = pready_reg;
  assign apb_o.pslverr = pslverr_reg;
  assign apb_o.prdata  = prdata_reg;
  assign pins_o.io     = io_out_reg;
  assign pins_o.io_oe  = io_oe_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  deselect_float_a : assert property (cs_n_s |=> io_oe_reg == 4'h0)
    else $error("Output driven while deselected");
  pause_float_a : assert property (paused |=> io_oe_reg == 4'h0)
    else $error("Output driven while paused");
  pause_keeps_count_a : assert property (paused && !cs_clear |=> $stable(bit_cnt_reg) && $stable(state_reg))
    else $error("Pause disturbed the sequence");
  reset_pin_a : assert property (!rstn_s |=> state_reg == ST_CMD && io_oe_reg == 4'h0)
    else $error("Reset pin did not reset the link");
  launch_fall_a : assert property ($changed(io_out_reg) |-> $past(sck_fall))
    else $error("Output changed away from a falling edge");
  sample_rise_a : assert property ($changed(bit_cnt_reg) |-> $past(sck_rise) || $past(cs_clear))
    else $error("Input counted away from a rising edge");
  repeat_reg_a : assert property (state_reg == ST_OUT && cmd_reg == `CMD_REG_READ && sck_rise && byte_done
                                  && !cs_clear && !paused |=> tx_sh_reg == reg_byte_reg)
    else $error("Register byte not repeated");
  quad_lines_a : assert property (io_oe_reg != 4'h0 && four_wire_command_mode |-> io_oe_reg == 4'hf)
    else $error("Four-wire output not on all lines");
  single_line_a : assert property (io_oe_reg != 4'h0 && !four_wire_command_mode |-> io_oe_reg == 4'h2)
    else $error("Single-line output not on line 1");
  msb_first_a : assert property (sck_rise && !cs_clear && !paused && !four_wire_command_mode
                                 |=> sh_reg[0] == $past(io_s[0]) && sh_reg[7:1] == $past(sh_reg[6:0]))
    else $error("Input not shifted most significant bit first");
  sector_map_a : assert property ({sector_w, 12'h000} <= addr_reg[`ADDR_MSB:0]
                                  && addr_reg[`ADDR_MSB:0] - {sector_w, 12'h000} < 23'h001000)
    else $error("Sector decode wrong");
  block_map_a : assert property (blk64_w == sector_w[10:4] && blk32_w == sector_w[10:3])
    else $error("Block decode not aligned on sectors");
  param_id_a : assert property (state_reg == ST_DUMMY && addr_reg[7:0] == 8'h08 && sck_rise && byte_done
                                && !cs_clear && !paused |=> tx_sh_reg == 8'h00)
    else $error("Parameter table id low byte wrong");

endmodule : serial_flash_bus_interface
`default_nettype wire

// ### spi_host_model.sv
/*
  Link master model: drives sck, chip select, IO0 and the pause line, captures IO1; four-wire bytes drive and capture IO3..IO0.
  Assumes clk_i is the bench clock; half an sck period is four clk_i cycles (160 ns period).
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] io_i,
  output var  logic       sck_o,
  output var  logic       cs_n_o,
  output var  logic [3:0] io_o,
  output var  logic [3:0] io_oe_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h8;
    io_oe_o = 4'h8;
  end
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask : half
  // Idle sck level alone selects mode 0 or mode 3
  task automatic sel(input logic mode3);
    @(posedge clk_i);
    sck_o <= mode3;
    half();
    cs_n_o <= 1'b0;
    io_oe_o <= 4'h9;
    half();
  endtask : sel
  // Sampled at the end of the high phase, where the slave still holds the bit
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o <= 1'b0;
      io_o[0] <= tx[i];
      half();
      sck_o <= 1'b1;
      half();
      rx[i] = io_i[1];
    end
  endtask : xb
  // Four-wire byte: a nibble per clock on IO3..IO0; lines are released while the slave answers
  task automatic xq(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    for (int i = 1; i >= 0; i--) begin
      sck_o <= 1'b0;
      io_o <= tx[4*i +: 4];
      io_oe_o <= drv ? 4'hf : 4'h0;
      half();
      sck_o <= 1'b1;
      half();
      rx[4*i +: 4] = io_i;
    end
  endtask : xq
  task automatic desel(input logic mode3);
    sck_o <= mode3;
    half();
    cs_n_o <= 1'b1;
    io_o <= 4'h8;
    io_oe_o <= 4'h8;
    half();
  endtask : desel
  task automatic hold_n(input logic v);
    io_o[3] <= v;
  endtask : hold_n
endmodule : spi_host_model
`default_nettype wire

// ### tb_serial_flash_bus_interface.sv
/*
  Self-checking bench: APB register tasks plus link transfers through the host model.
  Assumes pull-ups on every IO line and on unused pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "serial_flash_cfg.svh"
module tb_serial_flash_bus_interface;
  import serial_flash_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       reset_n = 1'b1;
  apb_req_t   apb_i = '0;
  apb_rsp_t   apb_o;
  pin_out_t   pins_o;
  pin_in_t    pins_i;
  logic       sck;
  logic       cs_n;
  logic [3:0] h_io;
  logic [3:0] h_oe;
  logic [3:0] wire_io;
  logic [7:0] rx;
  logic [7:0] wr_b[4] = '{8'h02, 8'hff, 8'hf1, 8'h23};
  logic [7:0] pr_b[5] = '{8'h5a, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [7:0] pr_e[9] = '{8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff, 8'hff};
  int         mismatches = 0;
  int         cmp_count = 0;
  // Undriven lines float up
  assign wire_io = (pins_o.io & pins_o.io_oe) | (h_io & h_oe & ~pins_o.io_oe) | ~(pins_o.io_oe | h_oe);
  assign pins_i = '{sck: sck, cs_n: cs_n, reset_n: reset_n, io: wire_io};
  serial_flash_bus_interface dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
    .pins_i(pins_i), .pins_o(pins_o));
  spi_host_model host_u (.clk_i(clk_sys_i), .io_i(wire_io), .sck_o(sck), .cs_n_o(cs_n), .io_o(h_io),
    .io_oe_o(h_oe));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int n;
    @(posedge clk_sys_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end else begin
      if (!wr) chk(apb_o.prdata, exp);
      chk({31'h0, apb_o.pslverr}, {31'h0, err});
      apb_i <= '0;
    end
  endtask : apb
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    apb(0, `OFS_CTRL, 0, 32'h0, 0);
    apb(0, `OFS_REG_BYTE, 0, 32'h0, 0);
    apb(0, 12'h01c, 0, 32'h0, 1);
    $display("register test done");
    for (int m = 0; m < 2; m++) begin
      apb(1, `OFS_REG_BYTE, m ? 32'h3c : 32'ha5, 0, 0);
      host_u.sel(m[0]);
      host_u.xb(`CMD_REG_READ, rx);
      repeat (3) begin
        host_u.xb(8'h00, rx);
        chk({24'h0, rx}, m ? 32'h3c : 32'ha5);
      end
      host_u.desel(m[0]);
    end
    $display("mode test done");
    host_u.sel(0);
    host_u.xb(`CMD_REG_READ, rx);
    host_u.xb(8'h00, rx);
    host_u.hold_n(0);
    repeat (8) @(posedge clk_sys_i);
    chk({28'h0, pins_o.io_oe}, 32'h0);
    apb(0, `OFS_STATE, 0, 32'h3, 0);
    host_u.hold_n(1);
    host_u.xb(8'h00, rx);
    chk({24'h0, rx}, 32'h3c);
    host_u.desel(0);
    apb(1, `OFS_CTRL, 32'h1, 0, 0);
    host_u.sel(0);
    host_u.hold_n(0);
    host_u.xb(`CMD_REG_READ, rx);
    host_u.xb(8'h00, rx);
    chk({24'h0, rx}, 32'h3c);
    host_u.hold_n(1);
    host_u.desel(0);
    apb(1, `OFS_CTRL, 32'h0, 0, 0);
    $display("pause test done");
    apb(1, `OFS_CTRL, 32'h2, 0, 0);
    host_u.sel(0);
    host_u.xq(`CMD_REG_READ, 1'b1, rx);
    repeat (2) begin
      host_u.xq(8'h00, 1'b0, rx);
      chk({24'h0, rx}, 32'h3c);
    end
    host_u.desel(0);
    apb(1, `OFS_CTRL, 32'h0, 0, 0);
    $display("four-wire test done");
    host_u.sel(0);
    host_u.xb(`CMD_REG_READ, rx);
    host_u.xb(8'h00, rx);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk({28'h0, pins_o.io_oe}, 32'h0);
    reset_n <= 1'b1;
    host_u.desel(0);
    $display("reset pin test done");
    host_u.sel(0);
    foreach (wr_b[i]) host_u.xb(wr_b[i], rx);
    host_u.desel(0);
    apb(0, `OFS_ADDR, 0, 32'h7ff123, 0);
    apb(0, `OFS_SECTOR, 0, {1'b0, 7'h7f, 8'hff, 5'h0, 11'h7ff}, 0);
    apb(1, `OFS_LAST_CMD, 32'h77, 0, 0);
    apb(0, `OFS_LAST_CMD, 0, 32'h2, 0);
    $display("address test done");
    host_u.sel(1);
    foreach (pr_b[i]) host_u.xb(pr_b[i], rx);
    foreach (pr_e[i]) begin
      host_u.xb(8'h00, rx);
      chk({24'h0, rx}, {24'h0, pr_e[i]});
    end
    host_u.desel(1);
    $display("parameter test done");
    stop_test();
  end
endmodule : tb_serial_flash_bus_interface
`default_nettype wire
